// *** core/mmb_cfg.svh ***
// constants for the memory-mapped burst lane block
`ifndef MMB_CFG_SVH
`define MMB_CFG_SVH
`define MMB_MAX_DATA_W   1024
`define MMB_MAX_LANES    128
`define MMB_DATA_W       32
`define MMB_ADDR_W       32
`define MMB_BURST_W      8
`define MMB_MEM_DEPTH    16
`endif

// *** core/mmb_pkg.sv ***
// types shared by both ends of the memory-mapped burst link
`include "mmb_cfg.svh"
package mmb_pkg;
    typedef enum logic [2:0] {
        MMB_IDLE  = 3'b001,
        MMB_SINGL = 3'b010,
        MMB_BURST = 3'b100
    } mmb_state_t;
endpackage

// *** core/mmb_if.sv ***
// interface joining master end and fabric end
`timescale 1ns/1ps
`include "mmb_cfg.svh"
interface mmb_if #(
    parameter int DATA_W  = `MMB_DATA_W,
    parameter int ADDR_W  = `MMB_ADDR_W,
    parameter int BURST_W = `MMB_BURST_W
) (
    input wire logic clk,
    input wire logic srst
);
    logic [ADDR_W-1:0]   address;
    logic [DATA_W/8-1:0] lane_sel;
    logic [BURST_W-1:0]  burst_len;
    logic                read;
    logic                write;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic                rvalid;
    logic                wait_req;
    modport master (
        input  clk, srst, rdata, rvalid, wait_req,
        output address, lane_sel, burst_len, read, write, wdata
    );
    modport fabric (
        input  clk, srst, address, lane_sel, burst_len, read, write, wdata,
        output rdata, rvalid, wait_req
    );
endinterface

// *** core/mmb_master.sv ***
// master end: issues single and burst transfers on the link
`timescale 1ns/1ps
`include "mmb_cfg.svh"
// Notes on behaviour
// - data path configurable up to 1024 bits
// - lane mask up to 128 bits, one per byte
// - lane mask may accompany reads too
// - bursts drive every lane bit active
// - master presents full lane mask on bursts
// - address, count, mask held through burst
// - active lanes form one contiguous group
// - master issues byte addresses only
module mmb_master
    import mmb_pkg::*;
#(
    parameter int DATA_W  = `MMB_DATA_W,
    parameter int ADDR_W  = `MMB_ADDR_W,
    parameter int BURST_W = `MMB_BURST_W
) (
    // link
    mmb_if.master               bus,
    // user request
    input  wire logic              req,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [$clog2(DATA_W/8+1)-1:0] req_bytes,
    input  wire logic [BURST_W-1:0] req_len,
    input  wire logic [DATA_W-1:0] req_wdata,
    // user response
    output logic                   busy,
    output logic                   req_error,
    output logic                   beat_done,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_valid
);
    localparam int LANES = DATA_W / 8;
    localparam int LW    = $clog2(LANES) > 0 ? $clog2(LANES) : 1;
    localparam int CW    = $clog2(LANES + 1);

    // parameter checks, refused at elaboration
    if (DATA_W < 8 || DATA_W > `MMB_MAX_DATA_W) begin : g_bad_width
        $error("mmb_master: DATA_W out of range");
    end
    if ((DATA_W & (DATA_W - 1)) != 0) begin : g_bad_pow2
        $error("mmb_master: DATA_W not a power of two");
    end
    if (LANES > `MMB_MAX_LANES) begin : g_bad_lanes
        $error("mmb_master: too many lanes");
    end
    if (ADDR_W <= LW) begin : g_bad_addr
        $error("mmb_master: ADDR_W too narrow for byte lanes");
    end
    if (BURST_W < 2) begin : g_bad_burst
        $error("mmb_master: BURST_W too narrow for bursts");
    end

    // single clock and reset taken from the link
    wire logic clk_w  = bus.clk;
    wire logic srst_w = bus.srst;

    // transfer bookkeeping
    mmb_state_t          state;
    logic [BURST_W-1:0]  beats_left;
    logic [BURST_W-1:0]  reads_left;
    logic [LANES-1:0]    next_mask;
    logic [LW-1:0]       lane_ofs;
    logic                size_ok;
    logic                is_burst;
    logic                accept;
    logic                legal;
    logic                start;
    logic                beat_ok;
    logic                last_beat;
    logic                burst_end;

    // lane of the byte address; one lane leaves no offset bits
    assign lane_ofs = (LANES > 1) ? req_addr[LW-1:0] : '0;

    // size a power of two, group aligned to its own size
    assign size_ok = (req_bytes != '0)
                     && ((req_bytes & (req_bytes - CW'(1))) == '0)
                     && ((CW'(lane_ofs) & (req_bytes - CW'(1))) == '0);

    // one contiguous group of lanes from the offset upwards
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign next_mask[i] = (CW'(i) >= CW'(lane_ofs))
                              && (CW'(i) < CW'(lane_ofs) + req_bytes);
    end

    // request decode
    assign is_burst  = (req_len > BURST_W'(1));
    assign accept    = req && (state == MMB_IDLE);
    // a burst carries every lane, so it must start on a word boundary
    assign legal     = is_burst ? (lane_ofs == '0) : size_ok;
    assign start     = accept && legal;
    assign beat_ok   = !bus.wait_req && (bus.read || bus.write);
    assign last_beat = beat_ok && (bus.read || beats_left == BURST_W'(1));
    assign burst_end = (state == MMB_BURST)
                       && beats_left == '0 && reads_left == '0;

    // transfer state
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            state <= MMB_IDLE;
        end else begin
            unique case (state)
                MMB_IDLE: begin
                    if (accept && legal)
                        state <= is_burst ? MMB_BURST : MMB_SINGL;
                end
                MMB_SINGL: begin
                    if (!bus.wait_req && bus.write)
                        state <= MMB_IDLE;
                    else if (bus.rvalid)
                        state <= MMB_IDLE;
                end
                MMB_BURST: begin
                    if (beats_left == '0 && reads_left == '0)
                        state <= MMB_IDLE;
                end
                default: state <= MMB_IDLE;
            endcase
        end
    end

    // address, count and data loaded once, held to the final beat
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            bus.address   <= '0;
            bus.burst_len <= '0;
            bus.wdata     <= '0;
        end else if (start) begin
            bus.address   <= req_addr;
            bus.burst_len <= is_burst ? req_len : BURST_W'(1);
            bus.wdata     <= req_wdata;
        end
    end

    // lane mask: every lane on bursts, cleared once a burst is over
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            bus.lane_sel <= '0;
        end else if (start) begin
            bus.lane_sel <= is_burst ? '1 : next_mask;
        end else if (burst_end) begin
            bus.lane_sel <= '0;
        end
    end

    // strobes stand until the fabric takes the beat
    // a single transfer or a read burst ends after its one command
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            bus.read  <= 1'b0;
            bus.write <= 1'b0;
        end else if (start) begin
            bus.read  <= !req_write;
            bus.write <= req_write;
        end else if (last_beat) begin
            bus.read  <= 1'b0;
            bus.write <= 1'b0;
        end
    end

    // beats still to hand over; a read burst is a single command
    // a stalled beat leaves address, count and mask untouched
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            beats_left <= '0;
        end else if (start) begin
            beats_left <= is_burst ? req_len : BURST_W'(1);
        end else if (beat_ok) begin
            beats_left <= bus.read ? '0 : beats_left - BURST_W'(1);
        end
    end

    // read beats still to come back from the fabric
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            reads_left <= '0;
        end else if (start) begin
            reads_left <= req_write ? '0
                          : (is_burst ? req_len : BURST_W'(1));
        end else if (bus.rvalid && reads_left != '0) begin
            reads_left <= reads_left - BURST_W'(1);
        end
    end

    // user side status
    always_ff @(posedge clk_w) begin
        if (srst_w) begin
            busy      <= 1'b0;
            req_error <= 1'b0;
            beat_done <= 1'b0;
            rsp_rdata <= '0;
            rsp_valid <= 1'b0;
        end else begin
            busy      <= (state != MMB_IDLE) || (accept && legal);
            req_error <= accept && !legal;
            beat_done <= bus.write && !bus.wait_req;
            rsp_valid <= bus.rvalid;
            if (bus.rvalid)
                rsp_rdata <= bus.rdata;
        end
    end
endmodule

// *** core/mmb_fabric.sv ***
// fabric end: answers transfers from a small local memory
`timescale 1ns/1ps
`include "mmb_cfg.svh"
module mmb_fabric
    import mmb_pkg::*;
#(
    parameter int DATA_W  = `MMB_DATA_W,
    parameter int BURST_W = `MMB_BURST_W,
    parameter int DEPTH   = `MMB_MEM_DEPTH
) (
    // link
    mmb_if.fabric                bus,
    // user side
    input  wire logic            stall,
    output logic                 wr_seen,
    output logic [DATA_W/8-1:0]  wr_lanes
);
    localparam int LANES = DATA_W / 8;
    localparam int LS    = $clog2(LANES);
    localparam int DW    = $clog2(DEPTH);

    // parameter checks, refused at elaboration
    if (DATA_W < 8 || DATA_W > `MMB_MAX_DATA_W) begin : g_bad_width
        $error("mmb_fabric: DATA_W out of range");
    end
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("mmb_fabric: DEPTH must be a power of two");
    end

    logic [DATA_W-1:0]  mem [DEPTH];
    logic [DW-1:0]      ofs;
    logic               busy;

    wire logic [DW-1:0] word = bus.address[LS +: DW] + ofs;

    // writes honour lanes; burst writes arrive with all lanes set
    always_ff @(posedge bus.clk) begin
        if (bus.write && !bus.wait_req) begin
            for (int i = 0; i < LANES; i++)
                if (bus.lane_sel[i])
                    mem[word][8*i +: 8] <= bus.wdata[8*i +: 8];
        end
    end

    // beat counter and read answer
    always_ff @(posedge bus.clk) begin
        if (bus.srst) begin
            ofs        <= '0;
            busy       <= 1'b0;
            bus.rvalid <= 1'b0;
            bus.rdata  <= '0;
            bus.wait_req <= 1'b1;
            wr_seen    <= 1'b0;
            wr_lanes   <= '0;
        end else begin
            bus.wait_req <= stall;
            wr_seen      <= bus.write && !bus.wait_req;
            wr_lanes     <= bus.lane_sel;
            bus.rvalid   <= 1'b0;
            if (bus.write && !bus.wait_req)
                ofs <= (ofs + DW'(1) == bus.burst_len[DW-1:0]) ? '0
                       : ofs + DW'(1);
            if (bus.read && !bus.wait_req && !busy) begin
                busy <= bus.burst_len > BURST_W'(1);
                bus.rvalid <= 1'b1;
                bus.rdata  <= mem[word];
                // a single read leaves the beat offset at zero
                ofs        <= (bus.burst_len > BURST_W'(1)) ? ofs + DW'(1)
                              : '0;
            end else if (busy) begin
                bus.rvalid <= 1'b1;
                bus.rdata  <= mem[word];
                ofs        <= ofs + DW'(1);
                if (BURST_W'(ofs) + BURST_W'(1) >= bus.burst_len) begin
                    busy <= 1'b0;
                    ofs  <= '0;
                end
            end
        end
    end
endmodule

// *** tb/mmb_assertions.sv ***
// lane and burst checks watching the link
`timescale 1ns/1ps
module mmb_assertions (
    // link
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [31:0] address,
    input wire logic [3:0]  lane_sel,
    input wire logic [7:0]  burst_len,
    input wire logic        read,
    input wire logic        write,
    input wire logic        rvalid,
    input wire logic        wait_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire act = read | write;
    wire bst = act & (burst_len > 8'h01);
    AST_BURST_FULL: assert property (bst |-> lane_sel == 4'hf)
        else $error("burst lane mask not full");
    AST_HOLD_ADDR: assert property (act && wait_req |=> $stable(address))
        else $error("address moved while stalled");
    AST_HOLD_CTRL: assert property (bst && wait_req
        |=> act && $stable(burst_len) && $stable(lane_sel))
        else $error("burst count or mask moved while stalled");
    AST_CONTIG: assert property (act
        |-> ((lane_sel + (lane_sel & (~lane_sel + 4'h1))) & lane_sel) == 4'h0)
        else $error("lane mask not contiguous");
    AST_ALIGN: assert property (act
        |-> lane_sel inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
        else $error("lane group not aligned");
    AST_BURST_ADDR: assert property (bst |-> address[1:0] == 2'h0)
        else $error("burst byte address off a word");
    AST_ONE_DIR: assert property (!(read && write))
        else $error("read and write together");
    AST_RVALID_DIR: assert property (rvalid |-> !write)
        else $error("read data during a write");
    C_BRD: cover property (bst && read);
    C_BWR: cover property (bst && write);
    C_PRD: cover property (read && !bst && lane_sel != 4'hf);
endmodule

// *** tb/mm_bus_lane_and_burst_rules_tb.sv ***
// self-checking bench joining master and fabric ends
`timescale 1ns/1ps
module mm_bus_lane_and_burst_rules_tb;
    logic        clk = 1'b0, srst = 1'b1, req = 1'b0, req_write = 1'b0;
    logic        stall = 1'b0, busy, req_error, beat_done, rsp_valid, wr_seen;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rs = 32'hbf58;
    logic [31:0] rsp_rdata, mem [16];
    logic [2:0]  req_bytes = 3'h1, bt [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    logic [7:0]  req_len = 8'h01;
    logic [3:0]  wr_lanes, kn [16] = '{default: 4'h0};
    int          failures = 0, compares = 0;
    mmb_if u_if (.clk(clk), .srst(srst));
    mmb_master i_mmb_master (.bus(u_if.master), .req(req),
        .req_write(req_write), .req_addr(req_addr), .req_bytes(req_bytes),
        .req_len(req_len), .req_wdata(req_wdata), .busy(busy),
        .req_error(req_error), .beat_done(beat_done),
        .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid));
    mmb_fabric i_mmb_fabric (.bus(u_if.fabric), .stall(stall),
        .wr_seen(wr_seen), .wr_lanes(wr_lanes));
    mmb_assertions i_mmb_assertions (.clk(clk), .srst(srst),
        .address(u_if.address), .lane_sel(u_if.lane_sel),
        .burst_len(u_if.burst_len), .read(u_if.read), .write(u_if.write),
        .rvalid(u_if.rvalid), .wait_req(u_if.wait_req));
    initial forever #5 clk = ~clk;
    function logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        xs = rs;
    endfunction
    function automatic logic [3:0] lm(logic [5:0] a, logic [2:0] b);
        lm = 4'(((8'h1 << b) - 8'h1) << a[1:0]);
    endfunction
    function automatic logic [31:0] bm(logic [3:0] m);
        bm = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction
    always @(posedge clk) stall <= (xs() & 32'h3) == 32'h0;
    task automatic chk(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic xfer(logic w, logic [5:0] a, logic [2:0] b, logic [7:0] n);
        logic [3:0]  m, sl;
        logic [31:0] d, rd, sa, k_m;
        logic        er, seen, ee;
        int          k, beats, rds;
        m = lm(a, b);
        d = xs();
        er = 1'b0;
        seen = 1'b0;
        beats = 0;
        rds = 0;
        ee = (n == 8'h01) ? (b == 3'h3 || a[1:0] % b != 3'h0)
                          : (a[1:0] != 2'h0);
        @(posedge clk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= {26'h0, a};
        req_bytes <= b;
        req_len <= n;
        req_wdata <= d;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            req <= 1'b0;
            #1;
            if ((u_if.read | u_if.write) === 1'b1) begin
                seen = 1'b1;
                sa = u_if.address;
                sl = u_if.lane_sel;
            end
            if (req_error === 1'b1) er = 1'b1;
            if (beat_done === 1'b1) beats++;
            if (rsp_valid === 1'b1) begin
                rd = rsp_rdata;
                rds++;
            end
            if (wr_seen === 1'b1) chk(wr_lanes, m);
            if (k > 1 && busy === 1'b0) break;
        end
        if (k == 300) begin
            failures++;
            conclude();
        end
        chk(er, ee);
        chk(seen, !ee);
        if (!ee) begin
            chk(sa, a);
            chk(sl, m);
            chk(beats, w ? n : 8'h00);
            chk(rds, w ? 8'h00 : n);
        end
        k_m = bm(m & kn[a[5:2]]);
        if (!ee && n == 8'h01 && w) begin
            mem[a[5:2]] = (mem[a[5:2]] & ~bm(m)) | (d & bm(m));
            kn[a[5:2]] = kn[a[5:2]] | m;
        end
        else if (!ee && n == 8'h01) chk(rd & k_m, mem[a[5:2]] & k_m);
    endtask
    initial begin
        int          i;
        logic [31:0] r;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1;
        xfer(1'b1, 6'd60, 3'h4, 8'h01);
        xfer(1'b1, 6'd61, 3'h1, 8'h01);
        xfer(1'b0, 6'd62, 3'h2, 8'h01);
        xfer(1'b0, 6'd1, 3'h2, 8'h01);
        xfer(1'b1, 6'd2, 3'h4, 8'h01);
        xfer(1'b0, 6'd0, 3'h3, 8'h01);
        for (i = 0; i < 40; i++) begin
            r = xs();
            if (r[3:0] == 4'h0)
                xfer(1'b0, {r[9:6], 2'h0}, 3'h4, {5'h0, r[12:10]} + 8'h2);
            else xfer(r[4], r[10:5], bt[r[12:11]], 8'h01);
        end
        xfer(1'b0, 6'd2, 3'h4, 8'h02);
        xfer(1'b1, 6'd0, 3'h4, 8'h04);
        conclude();
    end
endmodule
